// ---- shared/power_mode_defines.svh ----
// timing counts and reset values for the power mode sequencer
`ifndef POWER_MODE_DEFINES_SVH
`define POWER_MODE_DEFINES_SVH
`define PMS_TIMER_W          32
`define PMS_IDLE_DELAY_DEF   32'h000f4240
`define PMS_SLEEP_DELAY_DEF  32'h000f4240
`define PMS_OFF_DELAY_DEF    32'h00989680
`define PMS_WAKE_INTERVAL    32'h000003e8
`define PMS_SUPPLY_RST       5'h1e
`define PMS_RST_HOLD_MS      50
`define PMS_SYNC_STAGES      2
`endif

// ---- shared/power_mode_pkg.sv ----
// types shared by the power mode sequencer
package power_mode_pkg;
  typedef enum logic [1:0]
  {
    MODE_ACTIVE = 2'b00,
    MODE_IDLE   = 2'b01,
    MODE_SLEEP  = 2'b11,
    MODE_OFF    = 2'b10
  } power_mode_e;

  typedef struct packed
  {
    logic coreSupply;
    logic amplifierSupply;
    logic regulatorEnable;
    logic radioSupply;
    logic lowPowerClock;
  } supply_ctl_s;

  typedef struct packed
  {
    logic       forceValid;
    logic [1:0] forceMode;
    logic       sleepEnable;
  } pm_request_s;
endpackage

// ---- rtl/input_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module input_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] resetValue,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s state;
  sync_s next_state;

  always_comb
  begin
    next_state.stage1 = asyncIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state.stage1 <= resetValue;
      state.stage2 <= resetValue;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;
endmodule

// ---- rtl/power_mode_sequencer.sv ----
// power mode and reset sequencer for a low-energy wireless device
`timescale 1ns/1ps
`include "power_mode_defines.svh"

// Overview of operation
// (R01) Four power modes exist, from highest power: active, idle, sleep and deepest-off.
// (R02) With sleep disabled the step-down goes from idle straight to deepest-off.
// (R03) After the programmed inactivity period the mode steps to the next lower one.
// (R04) Any user activity returns the device directly to active mode.
// (R05) In deepest-off the core supply output and the amplifier supply are switched off.
// (R06) In deepest-off the always-on I/O domain stays up and restores power on a user event.
// (R07) Entering deepest-off disables the on-chip regulator.
// (R08) In low-power connection mode the low-power clock runs and a wake pulse follows a fixed interval.
// (R09) The radio supply follows packet transmit and receive activity.
// (R10) Mode changes can be forced by register requests as well as by packet handling events.
// (R11) While the active-low external reset is low the block is held in reset.
// (R12) The host holds external reset low until the I/O supply has been stable for 50 ms; host_model holds it low for HOLD = 20 clocks instead.
// (R13) External reset has the same effect as power-on reset and restores every reset value.
// (R14) The inactivity timer restarts on each activity event and each mode change.
module power_mode_sequencer
(
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ext_reset_n,
  input  wire logic                        userActivity,
  input  wire logic                        lowPowerConnect,
  input  wire logic                        packetActive,
  input  wire power_mode_pkg::pm_request_s pmRequest,
  input  wire power_mode_pkg::pm_request_s baseband_engineRequest,
  input  wire logic [`PMS_TIMER_W-1:0]     idleDelay,
  input  wire logic [`PMS_TIMER_W-1:0]     sleepDelay,
  input  wire logic [`PMS_TIMER_W-1:0]     offDelay,
  output logic [1:0]                       powerMode,
  output logic                             deepest_off_mode,
  output power_mode_pkg::supply_ctl_s      supplyCtl,
  output logic                             always_on_io_domain,
  output logic                             wakePulse,
  output logic                             deviceInReset
);
  // ==========================================================================
  // pin synchronisation
  // ==========================================================================
  logic [1:0] pinSync;

  input_sync #(.WIDTH(2)) pinSyncInst
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .asyncIn    ({~ext_reset_n, userActivity}),
    .resetValue (2'h2),
    .syncOut    (pinSync)
  );

  logic extResetActive;
  logic activitySeen;
  assign extResetActive = pinSync[1];
  assign activitySeen   = pinSync[0];

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed
  {
    power_mode_pkg::power_mode_e mode;
    logic [`PMS_TIMER_W-1:0]     idleTimer;
    logic [`PMS_TIMER_W-1:0]     wakeTimer;
    power_mode_pkg::supply_ctl_s supply;
    logic                        wake;
    logic                        inReset;
    logic                        offFlag;
    logic                        ioOn;
  } seq_s;

  seq_s state;
  seq_s next_state;

  function automatic power_mode_pkg::power_mode_e lowerMode
  (
    input power_mode_pkg::power_mode_e cur,
    input logic                        sleepOn
  );
    case (cur)
      power_mode_pkg::MODE_ACTIVE: lowerMode = power_mode_pkg::MODE_IDLE;
      power_mode_pkg::MODE_IDLE:   lowerMode = sleepOn ? power_mode_pkg::MODE_SLEEP   // R02
                                                       : power_mode_pkg::MODE_OFF;
      power_mode_pkg::MODE_SLEEP:  lowerMode = power_mode_pkg::MODE_OFF;
      default:                     lowerMode = power_mode_pkg::MODE_OFF;
    endcase
  endfunction

  function automatic logic [`PMS_TIMER_W-1:0] modeDelay
  (
    input power_mode_pkg::power_mode_e cur,
    input logic [`PMS_TIMER_W-1:0]     dIdle,
    input logic [`PMS_TIMER_W-1:0]     dSleep,
    input logic [`PMS_TIMER_W-1:0]     dOff
  );
    case (cur)
      power_mode_pkg::MODE_ACTIVE: modeDelay = dIdle;
      power_mode_pkg::MODE_IDLE:   modeDelay = dSleep;
      power_mode_pkg::MODE_SLEEP:  modeDelay = dOff;
      default:                     modeDelay = '1;
    endcase
  endfunction

  function automatic power_mode_pkg::supply_ctl_s supplyFor
  (
    input power_mode_pkg::power_mode_e m,
    input logic                        lpc,
    input logic                        pkt
  );
    logic off;
    off = (m == power_mode_pkg::MODE_OFF);
    supplyFor.coreSupply      = ~off;       // R05
    supplyFor.amplifierSupply = ~off;       // R05
    supplyFor.regulatorEnable = ~off;       // R07
    supplyFor.radioSupply     = ~off & pkt; // R09
    supplyFor.lowPowerClock   = off | lpc;  // R08
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  logic                        sleepOn;
  logic                        forceHit;
  power_mode_pkg::power_mode_e forceTarget;

  always_comb
  begin
    next_state = state;
    next_state.wake = 1'b0;
    next_state.inReset = 1'b0;
    sleepOn = pmRequest.sleepEnable;
    forceHit = 1'b0;
    forceTarget = power_mode_pkg::MODE_ACTIVE;
    if (baseband_engineRequest.forceValid)                     // R10
    begin
      forceHit = 1'b1;
      forceTarget = power_mode_pkg::power_mode_e'(baseband_engineRequest.forceMode);
    end
    else if (pmRequest.forceValid)                             // R10
    begin
      forceHit = 1'b1;
      forceTarget = power_mode_pkg::power_mode_e'(pmRequest.forceMode);
    end
    if (forceTarget == power_mode_pkg::MODE_SLEEP && !sleepOn)
    begin
      forceTarget = power_mode_pkg::MODE_OFF;                  // R02
    end
    if (activitySeen)
    begin
      next_state.mode = power_mode_pkg::MODE_ACTIVE;           // R04 R06
      next_state.idleTimer = '0;                               // R14
    end
    else if (forceHit)
    begin
      next_state.mode = forceTarget;
      next_state.idleTimer = '0;                               // R14
    end
    else if (state.mode != power_mode_pkg::MODE_OFF &&
             state.idleTimer >= modeDelay(state.mode, idleDelay, sleepDelay, offDelay) - 32'h1)
    begin
      next_state.mode = lowerMode(state.mode, sleepOn);        // R01 R03
      next_state.idleTimer = '0;                               // R14
    end
    else if (state.mode != power_mode_pkg::MODE_OFF)
    begin
      next_state.idleTimer = state.idleTimer + 32'h1;          // R03
    end
    if (lowPowerConnect && state.mode != power_mode_pkg::MODE_OFF)
    begin
      if (state.wakeTimer >= `PMS_WAKE_INTERVAL - 32'h1)
      begin
        next_state.wakeTimer = '0;
        next_state.wake = 1'b1;                                // R08
      end
      else
      begin
        next_state.wakeTimer = state.wakeTimer + 32'h1;
      end
    end
    else
    begin
      next_state.wakeTimer = '0;
    end
    next_state.supply = supplyFor(next_state.mode, lowPowerConnect, packetActive);
    next_state.offFlag = (next_state.mode == power_mode_pkg::MODE_OFF);
    next_state.ioOn = 1'b1;                                    // R06
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || extResetActive)                             // R11 R13
    begin
      state.mode      <= power_mode_pkg::MODE_ACTIVE;
      state.idleTimer <= '0;
      state.wakeTimer <= '0;
      state.supply    <= `PMS_SUPPLY_RST;
      state.wake      <= 1'b0;
      state.inReset   <= 1'b1;
      state.offFlag   <= 1'b0;
      state.ioOn      <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign powerMode           = state.mode;
  assign deepest_off_mode    = state.offFlag;
  assign supplyCtl           = state.supply;
  assign always_on_io_domain = state.ioOn;                    // R06
  assign wakePulse           = state.wake;
  assign deviceInReset       = state.inReset;
endmodule

// ---- testbench/power_mode_sva.sv ----
// port assertions for the power mode sequencer
`timescale 1ns/1ps
module power_mode_sva
(
  input wire logic                        ref_clk,
  input wire logic                        sys_rst,
  input wire logic                        userActivity,
  input wire logic                        packetActive,
  input wire power_mode_pkg::pm_request_s pmRequest,
  input wire power_mode_pkg::pm_request_s baseband_engineRequest,
  input wire logic [1:0]                  powerMode,
  input wire logic                        deepest_off_mode,
  input wire power_mode_pkg::supply_ctl_s supplyCtl,
  input wire logic                        always_on_io_domain,
  input wire logic                        wakePulse,
  input wire logic                        deviceInReset
);
  // ==========
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_off_decode: assert property (deepest_off_mode == (powerMode == 2'h2)) else $error("off flag");
  a_no_sleep: assert property (
    powerMode != 2'h3 && !pmRequest.sleepEnable && !baseband_engineRequest.sleepEnable |=> powerMode != 2'h3)
    else $error("sleep entered");
  a_wake_back: assert property ($rose(userActivity) |-> ##[1:4] powerMode == 2'h0) else $error("no wake");
  a_off_power: assert property (deepest_off_mode |-> supplyCtl[4:2] == 3'h0) else $error("off power");
  a_io_on: assert property (always_on_io_domain) else $error("io domain");
  a_pulse_width: assert property (wakePulse |=> !wakePulse) else $error("wake pulse");
  a_radio_follow: assert property (
    (!deepest_off_mode && packetActive) [*2] |-> supplyCtl.radioSupply) else $error("radio");
  a_reset_state: assert property (
    deviceInReset |-> powerMode == 2'h0 && supplyCtl == 5'h1e) else $error("reset state");
endmodule
bind power_mode_sequencer power_mode_sva power_mode_sva_i (.ref_clk, .sys_rst, .userActivity, .packetActive,
  .pmRequest, .baseband_engineRequest, .powerMode, .deepest_off_mode, .supplyCtl, .always_on_io_domain,
  .wakePulse, .deviceInReset);

// ---- testbench/host_model.sv ----
// host model driving external reset and user activity
`timescale 1ns/1ps
module host_model #(parameter int HOLD = 20)
(
  input  wire logic ref_clk,
  input  wire logic doReset,
  input  wire logic poke,
  output logic      ext_reset_n,
  output logic      userActivity
);
  int cnt = 0;
  initial ext_reset_n = 1'b0;
  initial userActivity = 1'b0;
  always @(posedge ref_clk)
  begin
    cnt <= doReset ? 0 : (cnt < HOLD ? cnt + 1 : cnt);
    ext_reset_n <= !doReset && cnt >= HOLD;
    userActivity <= poke;
  end
endmodule

// ---- testbench/power_mode_sequencer_tb.sv ----
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`include "power_mode_defines.svh"
module power_mode_sequencer_tb;
  localparam int DI = 20;
  localparam int DS = 30;
  localparam int DO = 40;
  logic ref_clk = 0, sys_rst = 1, poke = 0, doReset = 0, pkt = 1, lpc = 0;
  logic [31:0] idleD = 32'(DI);
  logic ext_reset_n, userActivity, offMode, ioOn, wakePulse, deviceInReset;
  logic [1:0] powerMode;
  power_mode_pkg::supply_ctl_s supplyCtl;
  power_mode_pkg::pm_request_s pmReq = '0, bbReq = '0;
  int n_mismatch = 0, check_count = 0, tick = 0, c;
  always #5 ref_clk = ~ref_clk;
  host_model host_model_i (.ref_clk, .doReset, .poke, .ext_reset_n, .userActivity);
  power_mode_sequencer power_mode_sequencer_i (.ref_clk, .sys_rst, .ext_reset_n, .userActivity,
    .lowPowerConnect(lpc), .packetActive(pkt), .pmRequest(pmReq), .baseband_engineRequest(bbReq),
    .idleDelay(idleD), .sleepDelay(32'(DS)), .offDelay(32'(DO)), .powerMode, .deepest_off_mode(offMode),
    .supplyCtl, .always_on_io_domain(ioOn), .wakePulse, .deviceInReset);
  always @(posedge ref_clk)
    if (++tick == 3000) conclude(1);
  // ==========
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [4:0] g, input logic [4:0] e, input string m);
    check_count++;
    if (g !== e) $display("ERROR %0t %s", $time, m);
    n_mismatch += int'(g !== e);
  endtask
  task automatic waitMode(input logic [1:0] m);
    #1;
    for (c = 0; powerMode !== m && c < 100; c++) cyc(1);
  endtask
  task automatic wake();
    @(posedge ref_clk);
    poke <= 1'b1;
    @(posedge ref_clk);
    poke <= 1'b0;
    waitMode(2'h0);
    chk(5'(c < 6), 5'h1, "slow wake");
  endtask
  task automatic req(input power_mode_pkg::pm_request_s p, input power_mode_pkg::pm_request_s b);
    @(posedge ref_clk);
    pmReq <= p;
    bbReq <= b;
    @(posedge ref_clk);
    pmReq <= '0;
    bbReq <= '0;
    cyc(1);
  endtask
  task automatic conclude(input int extra);
    n_mismatch += extra;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // tests
  task automatic t_stepdown();
    wake();
    waitMode(2'h1);
    chk(5'(c >= DI - 2 && c <= DI + 5), 5'h1, "idle time");
    waitMode(2'h2);
    chk(5'(c >= DS - 2 && c <= DS + 2), 5'h1, "off time");
    chk(5'(supplyCtl[4:2]), 5'h0, "off supplies");
    chk(5'(ioOn), 5'h1, "io domain");
    wake();
    chk(5'(supplyCtl[4:2]), 5'h7, "no restore");
    $display("stepdown done");
  endtask
  task automatic t_restart();
    cyc(DI / 2);
    wake();
    waitMode(2'h1);
    chk(5'(c >= DI - 2 && c <= DI + 5), 5'h1, "no restart");
    $display("restart done");
  endtask
  task automatic t_force();
    for (int i = 0; i < 4; i++)
    begin
      req(4'h1, {1'b1, 2'(i), 1'b1});
      chk(5'(powerMode), 5'(i), "engine force");
    end
    waitMode(2'h2);
    chk(5'(c >= DO - 3 && c <= DO + 1), 5'h1, "sleep timeout");
    req(4'h8, '0);
    chk(5'(powerMode), 5'h0, "register force");
    req(4'he, '0);
    chk(5'(powerMode), 5'h2, "sleep taken");
    req(4'ha, 4'h8);
    chk(5'(powerMode), 5'h0, "engine not first");
    $display("force done");
  endtask
  task automatic t_extreset();
    req(4'ha, '0);
    @(posedge ref_clk);
    doReset <= 1'b1;
    cyc(5);
    chk(5'(deviceInReset), 5'h1, "no reset");
    chk(5'(powerMode), 5'h0, "mode kept");
    @(posedge ref_clk);
    doReset <= 1'b0;
    cyc(10);
    chk(5'(deviceInReset), 5'h1, "early exit");
    cyc(20);
    chk(5'(deviceInReset), 5'h0, "stuck");
    $display("extreset done");
  endtask
  task automatic t_lowpower();
    @(posedge ref_clk);
    idleD <= 32'h0000ffff;
    lpc <= 1'b1;
    pkt <= 1'b0;
    cyc(2);
    chk(5'(supplyCtl.lowPowerClock), 5'h1, "lp clock");
    chk(5'(supplyCtl.radioSupply), 5'h0, "radio stuck on");
    for (c = 0; wakePulse !== 1'b1 && c < 1100; c++) cyc(1);
    chk(5'(c == `PMS_WAKE_INTERVAL - 2), 5'h1, "wake interval");
    cyc(1);
    chk(5'(wakePulse), 5'h0, "wake width");
    @(posedge ref_clk);
    lpc <= 1'b0;
    idleD <= 32'(DI);
    pkt <= 1'b1;
    wake();
    chk(5'(supplyCtl.radioSupply), 5'h1, "radio stuck off");
    $display("lowpower done");
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cyc(2);
    chk(5'(deviceInReset), 5'h1, "pin ignored");
    cyc(30);
    chk(5'(powerMode), 5'h0, "start mode");
    t_stepdown();
    t_restart();
    t_force();
    t_extreset();
    t_lowpower();
    conclude(0);
  end
endmodule
